// File: alarm_pkg.sv
// alarm channel package: register map, field positions, modes, helpers
// assumes byte offsets on a simple strobed register port
package alarm_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] OFS_CONFIG  = 8'h20;
    localparam logic [7:0] OFS_CONTROL = 8'h24;
    localparam logic [7:0] OFS_TRIGGER = 8'h28;
    localparam logic [7:0] OFS_PULSE   = 8'h2C;

    // ==========================================================
    // field positions
    localparam int CFG_REPEAT_BIT  = 4;
    localparam int CFG_MODE_LSB    = 0;
    localparam int CTL_UPDATE_BIT  = 15;
    localparam int CTL_RUNNING_BIT = 8;
    localparam int CTL_HALT_BIT    = 4;
    localparam int CTL_GO_BIT      = 0;

    // ==========================================================
    // reset values
    localparam logic [31:0] FIRE_VALUE_RST = 32'h0000_0000;
    localparam logic [31:0] PULSE_LEN_RST  = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        MODE_ABSOLUTE = 2'h0,
        MODE_RELATIVE = 2'h1,
        MODE_COMBINED = 2'h2,
        MODE_RESERVED = 2'h3
    } fire_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h1,
        ST_ARMED = 2'h2
    } chan_state_t;

    // next compare target; reserved mode behaves as absolute
    function automatic logic [31:0] next_target(
        input fire_mode_t  mode,
        input logic        first,
        input logic [31:0] base,
        input logic [31:0] value
    );
        logic [31:0] sum;
        sum = 32'(base + value);
        case (mode)
            MODE_RELATIVE: next_target = sum;
            MODE_COMBINED: next_target = first ? value : sum;
            default:       next_target = value;
        endcase
    endfunction : next_target

endpackage : alarm_pkg

// File: alarm_match.sv
// compare unit: holds the target and flags a match with the timer
// assumes timer_count is produced on mclk
`timescale 1ns/1ps
module alarm_match #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    // control
    input  wire logic         arm,
    input  wire logic         load,
    input  wire logic [W-1:0] target_in,
    // timer and result
    input  wire logic [W-1:0] timer_count,
    output logic      [W-1:0] target,
    output logic              hit
);

    logic [W-1:0] target_r;

    always_ff @(posedge mclk) begin
        if (!rst_b)
            target_r <= '0;
        else if (load)
            target_r <= target_in;
    end

    assign target = target_r;
    assign hit    = arm && (timer_count == target_r);

endmodule : alarm_match

// File: alarm_pulse.sv
// output pulse stretcher: high for 'length' cycles after each fire
// assumes fire is a one-cycle pulse on mclk; a new fire retriggers
`timescale 1ns/1ps
module alarm_pulse #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    // trigger
    input  wire logic         fire,
    input  wire logic [W-1:0] length,
    // output
    output logic              pulse
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         pulse_r;

    assign cnt_nxt = fire ? length
                   : (cnt_r != '0) ? W'(cnt_r - 1'b1) : '0;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_r   <= '0;
            pulse_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            pulse_r <= (cnt_nxt != '0);
        end
    end

    assign pulse = pulse_r;

endmodule : alarm_pulse

// File: timer_alarm_channel.sv
// one alarm channel: register port, arming state, staged updates
// assumes timer_count comes from a timer on mclk; reg port is a
// single-cycle strobe interface, read data one cycle after reg_rd
`timescale 1ns/1ps

// Notes on behaviour
// - config bit 4 picks single or continuous
// - mode 00 fires on count equal value
// - mode 01 fires each value-sized advance
// - mode 10 absolute first, then relative
// - control bit 15 flags staged update
// - staging governed by flag only when enabled
// - update flag ignored while disabled
// - writing stop bit disables channel
// - writing start bit enables or restarts
// - 32-bit trigger value at 0x28, resets zero
// - pulse length sets output pulse duration
// - staged values apply at fire or start
// - disabled channel applies writes immediately
module timer_alarm_channel (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // timer source
    input  wire logic [31:0] timer_count,
    // alarm outputs
    output logic             alarm_pulse,
    output logic             alarm_event,
    output logic             channel_running_flag
);

    // ==========================================================
    // register decode
    wire wr_cfg  = reg_wr && (reg_addr == alarm_pkg::OFS_CONFIG);
    wire wr_ctl  = reg_wr && (reg_addr == alarm_pkg::OFS_CONTROL);
    wire wr_trig = reg_wr && (reg_addr == alarm_pkg::OFS_TRIGGER);
    wire wr_len  = reg_wr && (reg_addr == alarm_pkg::OFS_PULSE);

    wire go_strobe   = wr_ctl && reg_wdata[alarm_pkg::CTL_GO_BIT];
    wire halt_strobe = wr_ctl && reg_wdata[alarm_pkg::CTL_HALT_BIT];
    wire upd_strobe  = wr_ctl && reg_wdata[alarm_pkg::CTL_UPDATE_BIT];

    // ==========================================================
    // state
    alarm_pkg::chan_state_t state_r;
    alarm_pkg::chan_state_t state_nxt;
    alarm_pkg::fire_mode_t  fire_mode_r;
    logic        repeat_select_r;
    logic        staged_update_flag_r;
    logic [31:0] fire_value_r;
    logic [31:0] pulse_length_r;
    logic [31:0] act_value_r;
    logic [31:0] act_len_r;
    logic [31:0] reg_rdata_r;
    logic        event_r;
    logic [31:0] target;
    logic        hit;

    wire running = (state_r == alarm_pkg::ST_ARMED);
    // a start or stop in the same cycle overrides a coincident match
    wire fire    = hit && !go_strobe && !halt_strobe;
    wire apply   = running && staged_update_flag_r
                   && (fire || go_strobe);

    // values seen by the compare and pulse logic
    wire [31:0] eff_value = running ? act_value_r : fire_value_r;
    wire [31:0] eff_len   = running ? act_len_r : pulse_length_r;
    wire [31:0] use_value = apply ? fire_value_r : eff_value;
    wire [31:0] use_len   = apply ? pulse_length_r : eff_len;

    // ==========================================================
    // arming state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            alarm_pkg::ST_IDLE: begin
                if (go_strobe && !halt_strobe)
                    state_nxt = alarm_pkg::ST_ARMED;
            end
            alarm_pkg::ST_ARMED: begin
                if (halt_strobe)
                    state_nxt = alarm_pkg::ST_IDLE;
                else if (fire && !repeat_select_r)
                    state_nxt = alarm_pkg::ST_IDLE;
            end
            default: state_nxt = alarm_pkg::ST_IDLE;
        endcase
    end

    wire load_go   = go_strobe && !halt_strobe;
    wire load_fire = fire && repeat_select_r;
    // only a start computes the first target; each fire in continuous mode reloads it, stepping on in relative and combined modes
    wire [31:0] target_in = alarm_pkg::next_target(
        fire_mode_r, load_go,
        load_go ? timer_count : target, use_value);

    alarm_match #(
        .W (32)
    ) u_match (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .arm         (running),
        .load        (load_go || load_fire),
        .target_in   (target_in),
        .timer_count (timer_count),
        .target      (target),
        .hit         (hit)
    );

    alarm_pulse #(
        .W (32)
    ) u_pulse (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .fire   (fire),
        .length (use_len),
        .pulse  (alarm_pulse)
    );

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r         <= alarm_pkg::ST_IDLE;
            fire_mode_r     <= alarm_pkg::MODE_ABSOLUTE;
            repeat_select_r <= 1'b0;
            event_r         <= 1'b0;
        end else begin
            state_r <= state_nxt;
            event_r <= fire;
            // mode fields trusted to change only while idle
            if (wr_cfg) begin
                repeat_select_r <= reg_wdata[alarm_pkg::CFG_REPEAT_BIT];
                fire_mode_r <= alarm_pkg::fire_mode_t'(
                    reg_wdata[alarm_pkg::CFG_MODE_LSB +: 2]);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fire_value_r   <= alarm_pkg::FIRE_VALUE_RST;
            pulse_length_r <= alarm_pkg::PULSE_LEN_RST;
        end else begin
            if (wr_trig)
                fire_value_r <= reg_wdata;
            if (wr_len)
                pulse_length_r <= reg_wdata;
        end
    end

    // active copies follow the written ones only when idle or applied
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            act_value_r <= alarm_pkg::FIRE_VALUE_RST;
            act_len_r   <= alarm_pkg::PULSE_LEN_RST;
        end else if (!running || apply) begin
            // an apply takes the staged copy, not a coincident write
            act_value_r <= (wr_trig && !running) ? reg_wdata
                                                 : fire_value_r;
            act_len_r   <= (wr_len && !running) ? reg_wdata
                                                : pulse_length_r;
        end
    end

    // new request wins over a coincident apply
    always_ff @(posedge mclk) begin
        if (!rst_b)
            staged_update_flag_r <= 1'b0;
        else if (upd_strobe && running)
            staged_update_flag_r <= 1'b1;
        else if (apply || !running)
            staged_update_flag_r <= 1'b0;
    end

    // ==========================================================
    // read back
    wire [31:0] cfg_word = {27'h0, repeat_select_r, 2'h0, fire_mode_r};
    wire [31:0] ctl_word = {16'h0, staged_update_flag_r, 6'h0,
                            running, 8'h0};
    wire [31:0] rd_mux =
        (reg_addr == alarm_pkg::OFS_CONFIG)  ? cfg_word :
        (reg_addr == alarm_pkg::OFS_CONTROL) ? ctl_word :
        (reg_addr == alarm_pkg::OFS_TRIGGER) ? fire_value_r :
        (reg_addr == alarm_pkg::OFS_PULSE)   ? pulse_length_r :
                                               alarm_pkg::ZERO_WORD;

    always_ff @(posedge mclk) begin
        if (!rst_b)
            reg_rdata_r <= alarm_pkg::ZERO_WORD;
        else if (reg_rd)
            reg_rdata_r <= rd_mux;
    end

    assign reg_rdata            = reg_rdata_r;
    assign alarm_event          = event_r;
    assign channel_running_flag = running;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    chk_single_stops: assert property (
        fire && !repeat_select_r |=> !channel_running_flag)
        else $error("single mode did not stop after fire");

    chk_repeat_rearms: assert property (
        fire && repeat_select_r |=> channel_running_flag)
        else $error("continuous mode did not stay armed");

    chk_abs_target: assert property (
        load_go && fire_mode_r == alarm_pkg::MODE_ABSOLUTE
        |=> target == $past(use_value))
        else $error("absolute target not the trigger value");

    chk_rel_target: assert property (
        load_go && fire_mode_r == alarm_pkg::MODE_RELATIVE
        |=> target == 32'($past(timer_count) + $past(use_value)))
        else $error("relative target not count plus value");

    chk_comb_walk: assert property (
        load_fire && fire_mode_r == alarm_pkg::MODE_COMBINED
        |=> target == 32'($past(target) + $past(use_value)))
        else $error("combined mode did not step after fire");

    chk_update_set: assert property (
        upd_strobe && channel_running_flag |=> staged_update_flag_r)
        else $error("update flag not set while running");

    chk_update_ignored: assert property (
        upd_strobe && !channel_running_flag |=> !staged_update_flag_r)
        else $error("update flag set while disabled");

    chk_staged_hold: assert property (
        channel_running_flag && wr_trig && !apply
        |=> act_value_r == $past(act_value_r))
        else $error("active value changed without update");

    chk_idle_direct: assert property (
        !channel_running_flag && wr_trig && !go_strobe
        |=> act_value_r == $past(reg_wdata))
        else $error("idle write not applied at once");

    chk_halt_stops: assert property (
        halt_strobe |=> !channel_running_flag)
        else $error("stop did not disable channel");

    chk_go_starts: assert property (
        load_go |=> channel_running_flag)
        else $error("start did not enable channel");

    chk_pulse_event: assert property (
        fire && use_len != alarm_pkg::ZERO_WORD
        |=> alarm_event && alarm_pulse)
        else $error("fire gave no event and pulse");

    chk_trig_read: assert property (
        reg_rd && reg_addr == alarm_pkg::OFS_TRIGGER
        |=> reg_rdata == $past(fire_value_r))
        else $error("trigger value read back wrong");

    chk_rel_walk: assert property (
        load_fire && fire_mode_r == alarm_pkg::MODE_RELATIVE
        |=> target == 32'($past(target) + $past(use_value)))
        else $error("relative mode did not step after fire");

    chk_apply_clears: assert property (
        apply && !upd_strobe
        |=> !staged_update_flag_r)
        else $error("update flag not cleared by apply");

    chk_pulse_zero: assert property (
        fire && use_len == alarm_pkg::ZERO_WORD
        |=> !alarm_pulse)
        else $error("zero length still gave a pulse");

    chk_event_once: assert property (
        fire && !repeat_select_r
        |=> ##1 !alarm_event)
        else $error("single fire event lasted too long");

    chk_rdata_holds: assert property (
        !reg_rd
        |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    cov_single_fire: cover property (
        load_go && !repeat_select_r ##[1:50] fire);
    cov_comb_twice: cover property (
        fire && fire_mode_r == alarm_pkg::MODE_COMBINED
        ##[1:50] fire);
    cov_staged_apply: cover property (apply && fire);
    cov_rel_twice: cover property (
        fire && fire_mode_r == alarm_pkg::MODE_RELATIVE ##[1:20] fire);
    cov_halt_running: cover property (
        halt_strobe && channel_running_flag);

endmodule : timer_alarm_channel

// File: tb_timer_alarm_channel.sv
// bench for one alarm channel: a cycle model is checked every clock
// assumes a strobed register port and a timer count driven by the bench
`timescale 1ns/1ps
module tb_timer_alarm_channel;
    // ==========================================================
    // stimulus and model state
    logic        mclk        = 1'h0;
    logic        rst_b       = 1'h0;
    logic        reg_wr      = 1'h0;
    logic        reg_rd      = 1'h0;
    logic [7:0]  reg_addr    = 8'h00;
    logic [31:0] reg_wdata   = 32'h0;
    logic [31:0] tcount      = 32'h0;
    logic        tick        = 1'h0;
    logic [31:0] seed        = 32'h832A4BFF;
    logic [31:0] reg_rdata;
    logic        alarm_pulse;
    logic        alarm_event;
    logic        channel_running_flag;
    int          n_fail      = 0;
    int          compares    = 0;
    int          cycles      = 0;
    logic        m_run, m_rep, m_upd, m_ev, fire;
    logic [1:0]  m_mode;
    logic [31:0] m_tgt, m_val, m_len, m_fv, m_pl, m_cnt;

    timer_alarm_channel DUT (
        .mclk                 (mclk),
        .rst_b                (rst_b),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_rdata            (reg_rdata),
        .timer_count          (tcount),
        .alarm_pulse          (alarm_pulse),
        .alarm_event          (alarm_event),
        .channel_running_flag (channel_running_flag)
    );

    always #12.5 mclk = ~mclk;

    // ==========================================================
    // helpers
    task automatic wrap_up();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] tnext(input logic first,
                                          input logic [31:0] base);
        if (m_mode == 2'h1 || (m_mode == 2'h2 && !first))
            return base + m_val;
        return m_val;
    endfunction : tnext

    function automatic logic [31:0] mread(input logic [7:0] a);
        case (a)
            8'h20:   return {27'h0, m_rep, 2'h0, m_mode};
            8'h24:   return {16'h0, m_upd, 6'h0, m_run, 8'h0};
            8'h28:   return m_fv;
            8'h2C:   return m_pl;
            default: return 32'h0;
        endcase
    endfunction : mread

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        #1;
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        #1;
        reg_wr = 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        @(posedge mclk);
        #1;
        reg_rd = 1'h1;
        reg_addr = a;
        e = mread(a);
        @(posedge mclk);
        #1;
        reg_rd = 1'h0;
        check(reg_rdata, e);
    endtask : rd

    // ==========================================================
    // timer source and hang guard
    always @(posedge mclk) begin
        if (tick)
            tcount <= tcount + 32'h1;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ==========================================================
    // reference model, judged a little before the next edge
    always @(posedge mclk) begin
        m_ev = 1'h0;
        if (!rst_b) begin
            {m_run, m_rep, m_upd, m_mode} = 5'h0;
            {m_tgt, m_val, m_len, m_fv, m_pl, m_cnt} = '0;
        end else begin
            if (m_cnt != 32'h0)
                m_cnt = m_cnt - 32'h1;
            // a start or stop in the same cycle masks the match
            fire = m_run && tcount == m_tgt && !(reg_wr &&
                   reg_addr == 8'h24 && (reg_wdata[0] || reg_wdata[4]));
            if (fire) begin
                if (m_upd) begin
                    m_val = m_fv;
                    m_len = m_pl;
                    m_upd = 1'h0;
                end
                m_ev = 1'h1;
                m_cnt = m_len;
                m_tgt = tnext(1'h0, m_tgt);
                if (!m_rep) begin
                    m_run = 1'h0;
                    m_upd = 1'h0;
                end
            end
            if (reg_wr) begin
                case (reg_addr)
                    8'h20: begin
                        m_rep = reg_wdata[4];
                        m_mode = reg_wdata[1:0];
                    end
                    8'h28: m_fv = reg_wdata;
                    8'h2C: m_pl = reg_wdata;
                    8'h24: begin
                        if (reg_wdata[4]) begin
                            m_run = 1'h0;
                            m_upd = 1'h0;
                        end else if (reg_wdata[0]) begin
                            if (m_upd) begin
                                m_val = m_fv;
                                m_len = m_pl;
                            end
                            m_upd = 1'h0;
                            m_run = 1'h1;
                            m_tgt = tnext(1'h1, tcount);
                        end else if (reg_wdata[15] && m_run) begin
                            m_upd = 1'h1;
                        end
                    end
                    default: ;
                endcase
            end
            if (!m_run) begin
                m_val = m_fv;
                m_len = m_pl;
            end
        end
        #12;
        check(32'(alarm_event), 32'(m_ev));
        check(32'(alarm_pulse), 32'(m_cnt != 32'h0));
        check(32'(channel_running_flag), 32'(m_run));
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        rst_b = 1'h1;
        for (int i = 0; i < 5; i++)
            rd(i == 4 ? 8'h30 : 8'h20 + 8'(4 * i));
        repeat (3) begin
            wr(8'h28, rnd());
            rd(8'h28);
            wr(8'h2C, rnd());
            rd(8'h2C);
        end
        wr(8'h30, 32'hFFFFFFFF);
        rd(8'h30);
        // modes are only changed after a stop
        for (int m = 0; m < 3; m++) begin
            tick = 1'h0;
            tcount = 32'h3;
            wr(8'h28, 32'h8);
            wr(8'h2C, m == 0 ? 32'h0 : rnd() % 5);
            wr(8'h20, 32'(m) | (m != 0 ? 32'h10 : 32'h0));
            rd(8'h20);
            wr(8'h24, 32'h1);
            tick = 1'h1;
            repeat (30) @(posedge mclk);
            #1;
            wr(8'h24, 32'h10);
        end
        // timer frozen while staging, so no match lands on a write
        tick = 1'h0;
        tcount = 32'h3;
        wr(8'h20, 32'h11);
        wr(8'h2C, 32'h2);
        wr(8'h24, 32'h1);
        tick = 1'h1;
        repeat (10) @(posedge mclk);
        #1;
        tick = 1'h0;
        wr(8'h28, 32'h5);
        wr(8'h2C, 32'h1);
        rd(8'h28);
        wr(8'h24, 32'h8000);
        rd(8'h24);
        tick = 1'h1;
        repeat (20) @(posedge mclk);
        #1;
        tick = 1'h0;
        wr(8'h28, 32'h3);
        wr(8'h24, 32'h8000);
        wr(8'h24, 32'h1);
        tick = 1'h1;
        repeat (12) @(posedge mclk);
        #1;
        wr(8'h24, 32'h10);
        rd(8'h24);
        wr(8'h24, 32'h8000);
        rd(8'h24);
        wrap_up();
    end
endmodule : tb_timer_alarm_channel
